//--- hdl/dioc_pkg.sv
// Shared constants and types for the I/O card register bank and its host controller.
package dioc_pkg;
    localparam int DIOC_ADDR_W = 16;
    localparam int DIOC_DATA_W = 8;
    localparam logic [DIOC_ADDR_W-1:0] DIOC_DEF_BASE = 16'hC400;
    localparam logic [7:0] OFS_IO_RELEASE = 8'h00;
    localparam logic [7:0] OFS_AUX_DIR = 8'h02;
    localparam logic [7:0] OFS_AUX_OUT = 8'h03;
    localparam logic [7:0] OFS_IRQ_EN = 8'h05;
    localparam logic [7:0] OFS_AUX_STATUS = 8'h07;
    localparam logic [7:0] OFS_IRQ_POL = 8'h2A;
    localparam logic [7:0] OFS_PORT0 = 8'hC0;
    localparam logic [7:0] OFS_PORT1 = 8'hC4;
    localparam logic [7:0] OFS_PORT2 = 8'hC8;
    localparam logic [7:0] OFS_PORT3 = 8'hCC;
    localparam logic [7:0] OFS_TMR_A_CNT0 = 8'hD0;
    localparam logic [7:0] OFS_TMR_A_CNT1 = 8'hD4;
    localparam logic [7:0] OFS_TMR_A_CNT2 = 8'hD8;
    localparam logic [7:0] OFS_TMR_A_CTRL = 8'hDC;
    localparam logic [7:0] OFS_TMR_B_CNT0 = 8'hE0;
    localparam logic [7:0] OFS_TMR_B_CNT1 = 8'hE4;
    localparam logic [7:0] OFS_TMR_B_CNT2 = 8'hE8;
    localparam logic [7:0] OFS_TMR_B_CTRL = 8'hEC;
    localparam logic [7:0] OFS_BOARD_NUM = 8'hF4;
    localparam int IO_RELEASE_BIT = 0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] IRQ_EN_MASK = 4'hF;
    localparam logic [2:0] POL_MASK = 3'h7;
    localparam int SEL_HI = 7;
    localparam int SEL_LO = 6;
    localparam int FMT_HI = 5;
    localparam int FMT_LO = 4;
    localparam int MODE_HI = 3;
    localparam int MODE_LO = 1;
    localparam int BCD_BIT = 0;
    localparam logic [1:0] SEL_READBACK = 2'h3;
    localparam logic [1:0] FMT_LATCH = 2'h0;
    localparam logic [1:0] FMT_LOW = 2'h1;
    localparam logic [1:0] FMT_HIGH = 2'h2;
    localparam logic [1:0] FMT_LOW_HIGH = 2'h3;
    localparam logic [2:0] MODE_MAX = 3'h5;
    // Host controller AXI4-Lite register map.
    localparam logic [3:0] CREG_CMD = 4'h0;
    localparam logic [3:0] CREG_WDATA = 4'h4;
    localparam logic [3:0] CREG_STATUS = 4'h8;
    localparam logic [3:0] CREG_RDATA = 4'hC;
    localparam int CMD_WRITE_BIT = 8;
    localparam int CMD_GO_BIT = 9;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    typedef logic [1:0] dioc_tsel_t;
endpackage

//--- hdl/dioc_if.sv
// Host I/O bus between the card and its host controller.
`timescale 1ns/1ps
interface dioc_if;
    import dioc_pkg::*;
    logic io_rd;
    logic io_wr;
    logic [DIOC_ADDR_W-1:0] io_addr;
    logic [DIOC_DATA_W-1:0] io_wdata;
    logic [DIOC_DATA_W-1:0] io_rdata;
    logic io_ack;
    logic irq;
    modport card (input io_rd, input io_wr, input io_addr, input io_wdata,
        output io_rdata, output io_ack, output irq);
    modport host (output io_rd, output io_wr, output io_addr, output io_wdata,
        input io_rdata, input io_ack, input irq);
endinterface

//--- hdl/dioc_card.sv
// Card end: byte register bank decoded from the card base address.
// Notes on behaviour
// RULE1 - Registers decode as offsets from card base.
// RULE2 - Release bit resets low, blocks digital I/O.
// RULE3 - Host sets release bit before digital I/O.
// RULE4 - Auxiliary direction bit: 0 input, 1 output.
// RULE5 - Auxiliary lines reset to inputs.
// RULE6 - Output auxiliary lines drive auxiliary output bits.
// RULE7 - Four channel enables, reset zero, upper zero.
// RULE8 - Aux status: channel levels and identity nibble.
// RULE9 - Polarity: 0 inverted, 1 direct, channels 0-2.
// RULE10 - Control word top bits select counter.
// RULE11 - Access format: latch, low, high, both.
// RULE12 - Three bit count mode field.
// RULE13 - Control word bit 0: binary or decimal.
// RULE14 - Two timers, three counters plus control.
// RULE15 - Board number read-only, low nibble.
// RULE16 - Four byte ports gated by release bit.
// RULE17 - Interrupt when enabled adjusted channel asserts.
`timescale 1ns/1ps
module dioc_card import dioc_pkg::*; #(
    parameter logic [DIOC_ADDR_W-1:0] CARD_BASE = DIOC_DEF_BASE,
    // Arbitrary value.
    parameter logic [3:0] AUX_IDENTITY = 4'h5,
    parameter logic [3:0] BOARD_NUMBER = 4'h0
) (
    input wire logic aclk,
    input wire logic aresetn,
    dioc_if.card bus,
    input wire logic [31:0] port_in,
    output logic [31:0] port_out,
    input wire logic [3:0] irq_source_line,
    input wire logic [7:0] auxiliary_line_in,
    output logic [7:0] auxiliary_line_out,
    output logic [7:0] auxiliary_line_oe,
    output logic [15:0] timer_a_ctrl,
    output logic [15:0] timer_b_ctrl
);
    logic io_release_r;
    logic [7:0] aux_dir_r;
    logic [7:0] aux_out_r;
    logic [3:0] irq_en_r;
    logic [2:0] irq_pol_r;
    logic [7:0] cnt_r [0:5];
    logic [7:0] tctl_r [0:5];
    logic [7:0] rdata_r;
    logic ack_r;
    logic irq_r;
    logic hit;
    logic [7:0] ofs;
    logic [7:0] rd_nxt;
    logic [3:0] chan_adj;
    logic [DIOC_ADDR_W-1:0] rel;

    // RULE1 base-relative decode.
    assign rel = bus.io_addr - CARD_BASE;
    assign hit = (bus.io_addr >= CARD_BASE) && (rel[DIOC_ADDR_W-1:8] == '0);
    assign ofs = rel[7:0];

    // RULE9 polarity per channel; channel 3 has no select.
    assign chan_adj = {irq_source_line[3],
        (irq_source_line[2:0] & irq_pol_r) | (~irq_source_line[2:0] & ~irq_pol_r)};

    // RULE2 release bit resets low.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            io_release_r <= 1'b0;
        end else if (bus.io_wr && hit && ofs == OFS_IO_RELEASE) begin
            io_release_r <= bus.io_wdata[IO_RELEASE_BIT];
        end
    end

    // RULE5 aux lines reset as inputs.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aux_dir_r <= RST_BYTE;
            aux_out_r <= RST_BYTE;
        end else if (bus.io_wr && hit) begin
            if (ofs == OFS_AUX_DIR) begin
                aux_dir_r <= bus.io_wdata;
            end
            if (ofs == OFS_AUX_OUT) begin
                aux_out_r <= bus.io_wdata;
            end
        end
    end

    // RULE7 enables reset to zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_r <= '0;
            irq_pol_r <= '0;
        end else if (bus.io_wr && hit) begin
            if (ofs == OFS_IRQ_EN) begin
                irq_en_r <= bus.io_wdata[3:0] & IRQ_EN_MASK;
            end
            if (ofs == OFS_IRQ_POL) begin
                irq_pol_r <= bus.io_wdata[2:0] & POL_MASK;
            end
        end
    end

    // RULE16 output ports latch only while released.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_out <= '0;
        end else if (bus.io_wr && hit && io_release_r) begin
            case (ofs)
                OFS_PORT0: port_out[7:0] <= bus.io_wdata;
                OFS_PORT1: port_out[15:8] <= bus.io_wdata;
                OFS_PORT2: port_out[23:16] <= bus.io_wdata;
                OFS_PORT3: port_out[31:24] <= bus.io_wdata;
                default: port_out <= port_out;
            endcase
        end
    end

    // RULE14 six counter bytes and per-counter control words.
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_cnt
            localparam int UNIT = gi / 3;
            localparam int SUB = gi % 3;
            localparam logic [7:0] CNT_OFS = (UNIT == 0) ? OFS_TMR_A_CNT0 : OFS_TMR_B_CNT0;
            localparam logic [7:0] CTL_OFS = (UNIT == 0) ? OFS_TMR_A_CTRL : OFS_TMR_B_CTRL;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cnt_r[gi] <= RST_BYTE;
                    tctl_r[gi] <= RST_BYTE;
                end else if (bus.io_wr && hit) begin
                    if (ofs == CNT_OFS + 8'(4 * SUB)) begin
                        cnt_r[gi] <= bus.io_wdata;
                    end
                    // RULE10 select field picks counter; read-back ignored.
                    if (ofs == CTL_OFS
                            && bus.io_wdata[SEL_HI:SEL_LO] == dioc_tsel_t'(SUB)
                            && bus.io_wdata[MODE_HI:MODE_LO] <= MODE_MAX) begin
                        // RULE11 RULE12 RULE13 format, mode and BCD kept.
                        tctl_r[gi] <= bus.io_wdata;
                    end
                end
            end
        end
    endgenerate

    // Read mux.
    always_comb begin
        rd_nxt = RST_BYTE;
        case (ofs)
            OFS_IO_RELEASE: rd_nxt = {7'h00, io_release_r};
            OFS_AUX_DIR: rd_nxt = aux_dir_r;
            OFS_AUX_OUT: rd_nxt = aux_out_r;
            OFS_IRQ_EN: rd_nxt = {4'h0, irq_en_r};
            // RULE8 levels plus identity.
            OFS_AUX_STATUS: rd_nxt = {AUX_IDENTITY, irq_source_line};
            OFS_IRQ_POL: rd_nxt = {5'h00, irq_pol_r};
            OFS_PORT0: rd_nxt = io_release_r ? port_in[7:0] : RST_BYTE;
            OFS_PORT1: rd_nxt = io_release_r ? port_in[15:8] : RST_BYTE;
            OFS_PORT2: rd_nxt = io_release_r ? port_in[23:16] : RST_BYTE;
            OFS_PORT3: rd_nxt = io_release_r ? port_in[31:24] : RST_BYTE;
            OFS_TMR_A_CNT0: rd_nxt = cnt_r[0];
            OFS_TMR_A_CNT1: rd_nxt = cnt_r[1];
            OFS_TMR_A_CNT2: rd_nxt = cnt_r[2];
            OFS_TMR_B_CNT0: rd_nxt = cnt_r[3];
            OFS_TMR_B_CNT1: rd_nxt = cnt_r[4];
            OFS_TMR_B_CNT2: rd_nxt = cnt_r[5];
            OFS_TMR_A_CTRL: rd_nxt = tctl_r[0];
            OFS_TMR_B_CTRL: rd_nxt = tctl_r[3];
            // RULE15 board number, read only.
            OFS_BOARD_NUM: rd_nxt = {4'h0, BOARD_NUMBER};
            default: rd_nxt = RST_BYTE;
        endcase
    end

    // Every access inside the window is acknowledged one cycle later.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_r <= RST_BYTE;
            ack_r <= 1'b0;
        end else begin
            ack_r <= (bus.io_rd || bus.io_wr) && hit;
            if (bus.io_rd && hit) begin
                rdata_r <= rd_nxt;
            end
        end
    end

    // RULE17 interrupt from enabled adjusted channels.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(chan_adj & irq_en_r);
        end
    end

    // RULE4 RULE6 aux direction and drive.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            auxiliary_line_out <= RST_BYTE;
            auxiliary_line_oe <= RST_BYTE;
        end else begin
            auxiliary_line_out <= aux_out_r & aux_dir_r;
            auxiliary_line_oe <= aux_dir_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_a_ctrl <= '0;
            timer_b_ctrl <= '0;
        end else begin
            timer_a_ctrl <= {tctl_r[1], tctl_r[0]};
            timer_b_ctrl <= {tctl_r[4], tctl_r[3]};
        end
    end

    assign bus.io_rdata = rdata_r;
    assign bus.io_ack = ack_r;
    assign bus.irq = irq_r;
endmodule // dioc_card

//--- hdl/dioc_host.sv
// Host end: AXI4-Lite slave that issues single byte I/O cycles to the card.
`timescale 1ns/1ps
module dioc_host import dioc_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq_seen,
    dioc_if.host bus
);
    typedef enum logic [1:0] {HS_IDLE, HS_WAIT} dioc_hst_t;
    dioc_hst_t st_r;
    logic aw_r, w_r;
    logic [3:0] awa_r;
    logic [31:0] wd_r;
    logic [15:0] cmd_r;
    logic [7:0] wbyte_r, rbyte_r;
    logic busy_r, rd_r, wr_r;
    logic [15:0] addr_r;
    logic [7:0] wdo_r;
    logic irq_r;
    logic go;

    assign go = aw_r && w_r && !s_axi_bvalid && awa_r == CREG_CMD && wd_r[CMD_GO_BIT]
        && !busy_r;

    // Write channel: capture address and data in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_r <= 1'b0;
            w_r <= 1'b0;
            awa_r <= '0;
            wd_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
            cmd_r <= '0;
            wbyte_r <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_r <= 1'b1;
                awa_r <= s_axi_awaddr[3:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_r <= 1'b1;
                wd_r <= s_axi_wdata;
            end
            if (aw_r && w_r && !s_axi_bvalid) begin
                aw_r <= 1'b0;
                w_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= AXI_OKAY;
                case (awa_r)
                    CREG_CMD: cmd_r <= wd_r[15:0];
                    CREG_WDATA: wbyte_r <= wd_r[7:0];
                    CREG_STATUS: s_axi_bresp <= AXI_OKAY;
                    CREG_RDATA: s_axi_bresp <= AXI_OKAY;
                    default: s_axi_bresp <= AXI_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_r && !s_axi_bvalid;
    assign s_axi_wready = !w_r && !s_axi_bvalid;

    // I/O cycle sequencer: a strobe stands until the card acknowledges.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= HS_IDLE;
            busy_r <= 1'b0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            addr_r <= '0;
            wdo_r <= '0;
            rbyte_r <= '0;
        end else begin
            case (st_r)
                HS_IDLE: begin
                    if (go) begin
                        busy_r <= 1'b1;
                        addr_r <= {wd_r[15:CMD_GO_BIT+1], 2'b00, wd_r[7:0]} | DIOC_DEF_BASE;
                        wr_r <= wd_r[CMD_WRITE_BIT];
                        rd_r <= !wd_r[CMD_WRITE_BIT];
                        wdo_r <= wbyte_r;
                        st_r <= HS_WAIT;
                    end
                end
                HS_WAIT: begin
                    if (bus.io_ack) begin
                        rd_r <= 1'b0;
                        wr_r <= 1'b0;
                        busy_r <= 1'b0;
                        if (rd_r) begin
                            rbyte_r <= bus.io_rdata;
                        end
                        st_r <= HS_IDLE;
                    end
                end
                default: st_r <= HS_IDLE;
            endcase
        end
    end

    // Read channel.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= AXI_OKAY;
            case (s_axi_araddr[3:0])
                CREG_CMD: s_axi_rdata <= {16'h0000, cmd_r};
                CREG_WDATA: s_axi_rdata <= {24'h000000, wbyte_r};
                CREG_STATUS: s_axi_rdata <= {30'h0, irq_r, busy_r};
                CREG_RDATA: s_axi_rdata <= {24'h000000, rbyte_r};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= AXI_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_r <= 1'b0;
            irq_seen <= 1'b0;
        end else begin
            irq_r <= bus.irq;
            irq_seen <= bus.irq;
        end
    end

    assign bus.io_rd = rd_r;
    assign bus.io_wr = wr_r;
    assign bus.io_addr = addr_r;
    assign bus.io_wdata = wdo_r;
endmodule // dioc_host

//--- bench/dioc_assertions.sv
// Concurrent checks on the I/O bus between the card and its host controller.
`timescale 1ns/1ps
module dioc_assertions import dioc_pkg::*; #(
    parameter logic [DIOC_ADDR_W-1:0] CARD_BASE = DIOC_DEF_BASE,
    parameter logic [3:0] AUX_IDENTITY = 4'h5,
    parameter logic [3:0] BOARD_NUMBER = 4'h0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [DIOC_ADDR_W-1:0] io_addr,
    input wire logic [DIOC_DATA_W-1:0] io_wdata,
    input wire logic [DIOC_DATA_W-1:0] io_rdata,
    input wire logic io_ack,
    input wire logic irq
);
    logic in_win;
    logic rd_win;
    logic release_r;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    assign in_win = (io_addr[15:8] == CARD_BASE[15:8]);
    assign rd_win = io_rd && in_win;
    // Tracks the release bit from taken writes; it lags the card by a cycle, which is harmless.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            release_r <= 1'b0;
        end else if (io_wr && io_ack && in_win && io_addr[7:0] == OFS_IO_RELEASE) begin
            release_r <= io_wdata[IO_RELEASE_BIT];
        end
    end
    a_ack_in_window: assert property ((io_rd || io_wr) && in_win |=> io_ack)
        else $error("strobe in card window not acknowledged");
    a_ack_has_cause: assert property (io_ack |-> $past(io_rd || io_wr) && $past(in_win))
        else $error("acknowledge without a strobe in the window");
    a_no_ack_outside: assert property ((io_rd || io_wr) && !in_win |=> !io_ack)
        else $error("strobe outside card window acknowledged");
    a_board_read: assert property (rd_win && io_addr[7:0] == OFS_BOARD_NUM
        |=> io_rdata == {4'h0, BOARD_NUMBER})
        else $error("board number read wrong");
    a_enable_upper: assert property (rd_win && io_addr[7:0] == OFS_IRQ_EN
        |=> io_rdata[7:4] == 4'h0)
        else $error("enable register upper bits not zero");
    a_polarity_upper: assert property (rd_win && io_addr[7:0] == OFS_IRQ_POL
        |=> io_rdata[7:3] == 5'h00)
        else $error("polarity register upper bits not zero");
    a_aux_identity: assert property (rd_win && io_addr[7:0] == OFS_AUX_STATUS
        |=> io_rdata[7:4] == AUX_IDENTITY)
        else $error("aux status identity nibble wrong");
    a_port_locked: assert property (rd_win && io_addr[7:4] == 4'hC && io_addr[1:0] == 2'h0
        && !release_r |=> io_rdata == 8'h00)
        else $error("port read returned data while locked");
    a_irq_quiet: assert property ($rose(aresetn) |-> !irq ##1 !irq)
        else $error("interrupt request raised right after reset");
    c_write: cover property (io_wr && io_ack);
    c_read: cover property (io_rd && io_ack);
    c_irq: cover property ($rose(irq));
endmodule // dioc_assertions

//--- bench/tb_dio_card_host_register_map.sv
// Testbench joining card and host over the I/O bus, driven through AXI4-Lite.
`timescale 1ns/1ps
module tb_dio_card_host_register_map import dioc_pkg::*;;
    // Board number and identity values are arbitrary.
    localparam logic [3:0] BNUM = 4'h9;
    localparam logic [3:0] AUXID = 4'hA;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] awaddr, wdata, araddr, port_in;
    logic [3:0] src;
    logic [7:0] aux_in;
    wire awready, wready, bvalid, arready, rvalid, irq_seen;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, port_out;
    wire [7:0] aux_out, aux_oe;
    wire [15:0] ta_ctrl, tb_ctrl;
    int err_count, samples_checked;
    dioc_if bif();
    dioc_card #(.CARD_BASE(DIOC_DEF_BASE), .AUX_IDENTITY(AUXID), .BOARD_NUMBER(BNUM)) i_dioc_card (
        .aclk(aclk), .aresetn(aresetn), .bus(bif), .port_in(port_in), .port_out(port_out),
        .irq_source_line(src), .auxiliary_line_in(aux_in), .auxiliary_line_out(aux_out),
        .auxiliary_line_oe(aux_oe), .timer_a_ctrl(ta_ctrl), .timer_b_ctrl(tb_ctrl));
    dioc_host i_dioc_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .irq_seen(irq_seen), .bus(bif));
    dioc_assertions #(.CARD_BASE(DIOC_DEF_BASE), .AUX_IDENTITY(AUXID), .BOARD_NUMBER(BNUM))
        i_dioc_assertions (.aclk(aclk), .aresetn(aresetn), .io_rd(bif.io_rd), .io_wr(bif.io_wr),
        .io_addr(bif.io_addr), .io_wdata(bif.io_wdata), .io_rdata(bif.io_rdata),
        .io_ack(bif.io_ack), .irq(bif.irq));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic end_sim();
        $display("Mismatches %0d, comparisons %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // Ready is sampled mid-cycle so the handshake edge is known before it arrives.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge aclk);
            ad = ad | awready;
            wd = wd | wready;
            @(posedge aclk);
            if (ad) awvalid <= 1'b0;
            if (wd) wvalid <= 1'b0;
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ad;
        @(posedge aclk);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ad = arready;
            @(posedge aclk);
        end while (!ad);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    task automatic card_io(input logic [7:0] ofs, input logic wr, input logic [7:0] d,
        output logic [7:0] q);
        logic [31:0] v;
        logic [1:0] r;
        int n;
        if (wr) axi_wr(CREG_WDATA, {24'h0, d}, r);
        axi_wr(CREG_CMD, {22'h0, 1'b1, wr, ofs}, r);
        n = 0;
        do begin
            axi_rd(CREG_STATUS, v, r);
            n++;
        end while (v[0] !== 1'b0 && n < 40);
        chk("io_done", {31'h0, v[0]}, 32'h0);
        axi_rd(CREG_RDATA, v, r);
        q = v[7:0];
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic [7:0] q;
        card_io(ofs, 1'b1, d, q);
    endtask
    task automatic rd_chk(input string n, input logic [7:0] ofs, input logic [7:0] e);
        logic [7:0] q;
        card_io(ofs, 1'b0, 8'h00, q);
        chk(n, {24'h0, q}, {24'h0, e});
    endtask
    task automatic irq_is(input logic e);
        // The request is registered, and the host copy lags one more cycle.
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk("irq", bif.irq, e);
        chk("irq_seen", irq_seen, e);
    endtask
    task automatic t_reset();
        rd_chk("release", OFS_IO_RELEASE, 8'h00);
        rd_chk("aux_dir", OFS_AUX_DIR, 8'h00);
        chk("aux_oe", aux_oe, 32'h0);
        rd_chk("irq_en", OFS_IRQ_EN, 8'h00);
    endtask
    task automatic t_ports();
        port_in <= 32'hC3A55A3C;
        wr(OFS_PORT0, 8'h77);
        chk("port_out_locked", port_out, 32'h0);
        rd_chk("port0_locked", OFS_PORT0, 8'h00);
        wr(OFS_IO_RELEASE, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_PORT0 + 8'(4 * i), 8'(8'h11 * (i + 1)));
            chk("port_out", port_out[8*i+:8], 32'(8'h11 * (i + 1)));
            rd_chk("port_in", OFS_PORT0 + 8'(4 * i), port_in[8*i+:8]);
        end
        wr(OFS_IO_RELEASE, 8'h00);
        rd_chk("port1_relocked", OFS_PORT1, 8'h00);
    endtask
    task automatic t_aux();
        wr(OFS_AUX_DIR, 8'hF0);
        wr(OFS_AUX_OUT, 8'hA5);
        chk("aux_oe", aux_oe, 32'hF0);
        chk("aux_out", aux_out & aux_oe, 32'hA0);
        rd_chk("aux_dir", OFS_AUX_DIR, 8'hF0);
        wr(OFS_AUX_DIR, 8'h00);
        chk("aux_oe_off", aux_oe, 32'h0);
    endtask
    task automatic t_irq();
        src <= 4'h0;
        wr(OFS_IRQ_POL, 8'hFF);
        rd_chk("pol", OFS_IRQ_POL, 8'h07);
        wr(OFS_IRQ_POL, 8'h00);
        wr(OFS_IRQ_EN, 8'hFF);
        rd_chk("irq_en", OFS_IRQ_EN, 8'h0F);
        irq_is(1'b1);
        src <= 4'h7;
        irq_is(1'b0);
        wr(OFS_IRQ_POL, 8'h07);
        irq_is(1'b1);
        wr(OFS_IRQ_EN, 8'h08);
        irq_is(1'b0);
        src <= 4'hF;
        irq_is(1'b1);
        rd_chk("status", OFS_AUX_STATUS, {AUXID, 4'hF});
        wr(OFS_IRQ_EN, 8'h00);
        irq_is(1'b0);
    endtask
    task automatic t_timer();
        logic [7:0] w;
        for (int i = 0; i < 6; i++) begin
            w = {2'b00, 2'(i), 3'(i), 1'(i)};
            wr(OFS_TMR_B_CTRL, w);
            chk("tb_ctrl0", tb_ctrl[7:0], w);
        end
        wr(OFS_TMR_B_CTRL, 8'h4B);
        chk("tb_ctrl1", tb_ctrl, 32'h4B1B);
        wr(OFS_TMR_B_CTRL, 8'hC2);
        wr(OFS_TMR_B_CTRL, 8'h0C);
        chk("tb_ctrl_hold", tb_ctrl, 32'h4B1B);
        rd_chk("tb_ctrl_rd", OFS_TMR_B_CTRL, 8'h1B);
        wr(OFS_TMR_A_CTRL, 8'h37);
        chk("ta_ctrl", ta_ctrl, 32'h0037);
        wr(OFS_TMR_A_CTRL, 8'h9A);
        chk("ta_ctrl_sel2", ta_ctrl, 32'h0037);
        wr(OFS_TMR_A_CNT1, 8'h5E);
        rd_chk("ta_cnt1", OFS_TMR_A_CNT1, 8'h5E);
        wr(OFS_TMR_B_CNT2, 8'h81);
        rd_chk("tb_cnt2", OFS_TMR_B_CNT2, 8'h81);
    endtask
    task automatic t_board();
        logic [31:0] v;
        logic [1:0] r;
        rd_chk("board", OFS_BOARD_NUM, {4'h0, BNUM});
        wr(OFS_BOARD_NUM, 8'hFF);
        rd_chk("board_ro", OFS_BOARD_NUM, {4'h0, BNUM});
        axi_rd(8'h06, v, r);
        chk("rresp_unmapped", r, AXI_SLVERR);
        axi_wr(8'h06, 32'h1, r);
        chk("bresp_unmapped", r, AXI_SLVERR);
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        end_sim();
    end
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, wdata, araddr, port_in} = 128'h0;
        src = 4'h0;
        aux_in = 8'h3C;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_ports();
        t_aux();
        t_irq();
        t_timer();
        t_board();
        end_sim();
    end
endmodule // tb_dio_card_host_register_map
